// ===== cor_defines.svh
`ifndef COR_DEFINES_SVH
`define COR_DEFINES_SVH
// register byte addresses on the wishbone bus (index times four)
`define COR_IDX_INDIRECT 6'h00
`define COR_IDX_TIMER 6'h01
`define COR_IDX_PCL 6'h02
`define COR_IDX_STATUS 6'h03
`define COR_IDX_BRS 6'h04
`define COR_IDX_TABLE_POINTER_LOW 6'h09
`define COR_IDX_WAKE 6'h0A
`define COR_ADR_INDIRECT 8'h00
`define COR_ADR_TIMER 8'h04
`define COR_ADR_PCL 8'h08
`define COR_ADR_STATUS 8'h0C
`define COR_ADR_BRS 8'h10
`define COR_ADR_TABLE_POINTER_LOW 8'h24
`define COR_ADR_WAKE 8'h28
`define COR_ADR_CONTROL 8'h40
`define COR_ADR_PCFULL 8'h44
`define COR_ADR_INSTR 8'h48
`define COR_ADR_EVENTS 8'h4C
`define COR_ADR_STACK 8'h50
`define COR_ADR_OPERAND 8'h54
// field positions
`define COR_CTL_EDGE 4
`define COR_CTL_PSA 3
`define COR_CTL_SRC 5
`define COR_ST_TO 4
`define COR_ST_PD 3
`define COR_ST_Z 2
`define COR_ST_HC 1
`define COR_ST_C 0
`define COR_WK_PORT 6
`define COR_WK_CONV 5
`define COR_WK_EXT 4
`define COR_WAKE_MASK 8'h70
`define COR_STATUS_RESET 8'h18
`define COR_PAGE_BITS 10
`define COR_PC_BITS 12
`define COR_STACK_DEPTH 8
`define COR_MEM_DEPTH 144
`define COR_SP_BITS 3
`define COR_PRESCALE_BITS 8
`endif

// ===== cor_pkg.sv
package cor_pkg;
    typedef enum logic [3:0] {
        COR_OP_NONE = 4'h0,
        COR_OP_JMP = 4'h1,
        COR_OP_CALL = 4'h2,
        COR_OP_LONG_JUMP = 4'h3,
        COR_OP_LONG_CALL = 4'h4,
        COR_OP_RET = 4'h5,
        COR_OP_ADDPC = 4'h6,
        COR_OP_TABLE_READ = 4'h7,
        COR_OP_SLEEP = 4'h8,
        COR_OP_WDTCLR = 4'h9,
        COR_OP_WDTOUT = 4'hA,
        COR_OP_STEP = 4'hB
    } cor_op_t;
    typedef enum logic [1:0] {
        COR_IDLE = 2'b00,
        COR_SECOND = 2'b01,
        COR_ACK = 2'b10
    } cor_state_t;
endpackage

// ===== cor_core.sv
`timescale 1ns/1ps
`include "cor_defines.svh"
// Summary of operation
// [RQ1] location zero has no cell; it reaches the data address held in bank select. Below 0x10 only timer and PCL writes reach; reads there return zero.
// [RQ2] timer counts pin edges of chosen polarity or instruction cycles; readable, writable.
// [RQ3] prescaler assign clear gives prescaler to timer; timer write clears prescaler.
// [RQ4] program counter spans 4K words in 1024-word pages.
// [RQ5] reset clears the whole program counter.
// [RQ6] short jump loads only the low 10 counter bits.
// [RQ7] short call loads low 10 bits and pushes next address.
// [RQ8] long jump loads all twelve counter bits.
// [RQ9] long call loads twelve bits and pushes current address plus one.
// [RQ10] every return loads the counter from the popped stack top.
// [RQ11] adding accumulator to counter low carries into upper bits.
// [RQ12] other writes to counter low replace only the low eight bits.
// [RQ13] one cycle per instruction; branches, long jump, long call, table read take two.
// [RQ14] bank select bits 7:6 pick bank, bits 5:0 pick indirect address.
// [RQ15] time-out flag set by sleep, watchdog clear, power up; cleared by time-out.
// [RQ16] power-down flag set at power on or watchdog clear; cleared by sleep.
// [RQ17] status holds zero, half carry and carry flags in bits 2..0.
// [RQ18] wake bit 6 lets port 6 changes wake the device.
// [RQ19] software sets wake bit 5 for conversion wake during conversion.
// [RQ20] wake bit 4 lets the external pin wake the device.
// [RQ21] 0x10..0x1F shared by all banks; 0x20..0x3F per bank.
module cor_core (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic TIMER_PIN,
    input wire logic PORT6_CHANGE,
    input wire logic EXT_PIN,
    input wire logic CONV_DONE,
    output logic WAKE,
    output logic [11:0] PC,
    output logic BUSY
);
    import cor_pkg::*;

    // ****************************************
    // bus decode
    // ****************************************
    cor_state_t state;
    logic req;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [11:0] opnd;
    logic [7:0] accum;
    logic [7:0] mem [0:`COR_MEM_DEPTH-1];
    logic [7:0] control;
    logic [7:0] timer;
    logic [7:0] prescale;
    logic [7:0] status;
    logic [7:0] brs;
    logic [7:0] table_pointer_low;
    logic [7:0] wake_en;
    logic [11:0] stack [0:`COR_STACK_DEPTH-1];
    logic [`COR_SP_BITS-1:0] sp;
    logic [11:0] ret_addr;
    logic [11:0] top;
    logic [12:0] add_sum;
    logic [7:0] mem_idx;
    logic mem_hit;
    logic indirect_wr;
    logic timer_wr;
    logic pcl_wr;
    logic instr_go;
    cor_op_t op;
    logic [2:0] pin_sync;
    logic [1:0] p6_sync;
    logic [2:0] ext_sync;
    logic [1:0] cd_sync;
    logic pin_edge;
    logic timer_tick;

    assign req = WB_CYC_I && WB_STB_I && state == COR_IDLE;
    assign wr = req && WB_WE_I && WB_SEL_I[0];
    assign wdata = WB_DAT_I[7:0];
    assign op = cor_op_t'(WB_DAT_I[3:0]);
    assign instr_go = wr && WB_ADR_I == `COR_ADR_INSTR;
    assign ret_addr = PC + 12'h001;
    assign top = stack[sp - 3'h1];
    assign add_sum = {1'b0, PC} + {5'h00, accum};

    // indirect: bank select low six bits name the target location
    always_comb begin
        mem_hit = 1'b0;
        mem_idx = 8'h00;
        if (brs[5:4] == 2'b01) begin
            mem_hit = 1'b1; // see [RQ21]
            mem_idx = {4'h0, brs[3:0]};
        end else if (brs[5] == 1'b1) begin
            mem_hit = 1'b1;
            mem_idx = 8'h10 + {1'b0, brs[7:6], brs[4:0]}; // see [RQ14] [RQ21]
        end
    end

    assign indirect_wr = wr && WB_ADR_I == `COR_ADR_INDIRECT; // see [RQ1]
    assign timer_wr = wr && (WB_ADR_I == `COR_ADR_TIMER ||
                             (indirect_wr && brs[5:0] == `COR_IDX_TIMER));
    assign pcl_wr = wr && (WB_ADR_I == `COR_ADR_PCL ||
                           (indirect_wr && brs[5:0] == `COR_IDX_PCL));

    always_comb begin
        rdata = 8'h00;
        unique case (WB_ADR_I)
            `COR_ADR_INDIRECT: rdata = mem_hit ? mem[mem_idx] : 8'h00; // see [RQ1]
            `COR_ADR_TIMER: rdata = timer;
            `COR_ADR_PCL: rdata = PC[7:0];
            `COR_ADR_STATUS: rdata = status;
            `COR_ADR_BRS: rdata = brs;
            `COR_ADR_TABLE_POINTER_LOW: rdata = table_pointer_low;
            `COR_ADR_WAKE: rdata = wake_en;
            `COR_ADR_CONTROL: rdata = control;
            `COR_ADR_PCFULL: rdata = PC[7:0];
            `COR_ADR_STACK: rdata = {5'h00, sp};
            `COR_ADR_OPERAND: rdata = accum;
            default: rdata = 8'h00;
        endcase
    end

    // ****************************************
    // bus handshake and instruction timing
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= COR_IDLE;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
            BUSY <= 1'b0;
        end else begin
            WB_ACK_O <= 1'b0;
            unique case (state)
                COR_IDLE: begin
                    if (req) begin
                        WB_DAT_O <= (WB_ADR_I == `COR_ADR_PCFULL) ? {20'h00000, PC}
                                    : {24'h000000, rdata};
                        if ((instr_go && op inside {COR_OP_JMP, COR_OP_CALL, COR_OP_LONG_JUMP,
                            COR_OP_LONG_CALL, COR_OP_RET, COR_OP_ADDPC, COR_OP_TABLE_READ}) ||
                            pcl_wr) begin
                            state <= COR_SECOND; // see [RQ13]
                            BUSY <= 1'b1;
                        end else begin
                            state <= COR_ACK;
                            WB_ACK_O <= 1'b1;
                        end
                    end
                end
                COR_SECOND: begin
                    state <= COR_ACK;
                    WB_ACK_O <= 1'b1;
                    BUSY <= 1'b0;
                end
                COR_ACK: state <= COR_IDLE;
                default: state <= COR_IDLE;
            endcase
        end
    end

    // ****************************************
    // program counter and stack
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PC <= 12'h000; // see [RQ5]
            sp <= '0;
            for (int i = 0; i < `COR_STACK_DEPTH; i++) begin
                stack[i] <= 12'h000;
            end
        end else if (instr_go) begin
            unique case (op)
                COR_OP_JMP: PC <= {PC[11:10], opnd[9:0]}; // see [RQ4] [RQ6]
                COR_OP_CALL: begin
                    PC <= {PC[11:10], opnd[9:0]}; // see [RQ7]
                    stack[sp] <= ret_addr;
                    sp <= sp + 3'h1;
                end
                COR_OP_LONG_JUMP: PC <= opnd; // see [RQ8]
                COR_OP_LONG_CALL: begin
                    PC <= opnd; // see [RQ9]
                    stack[sp] <= ret_addr;
                    sp <= sp + 3'h1;
                end
                COR_OP_RET: begin
                    PC <= top; // see [RQ10]
                    sp <= sp - 3'h1;
                end
                COR_OP_ADDPC: PC <= add_sum[11:0]; // see [RQ11]
                COR_OP_TABLE_READ, COR_OP_STEP: PC <= ret_addr;
                default: PC <= PC;
            endcase
        end else if (pcl_wr) begin
            PC <= {PC[11:8], wdata}; // see [RQ12]
        end
    end

    // operand and accumulator staging
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            opnd <= 12'h000;
            accum <= 8'h00;
        end else if (wr && WB_ADR_I == `COR_ADR_OPERAND) begin
            opnd <= WB_DAT_I[11:0];
            accum <= wdata;
        end
    end

    // ****************************************
    // timer and prescaler
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_sync <= 3'b000;
        end else begin
            pin_sync <= {pin_sync[1:0], TIMER_PIN};
        end
    end

    // edge select bit chooses falling (1) or rising (0) edge
    assign pin_edge = control[`COR_CTL_EDGE] ? (pin_sync[2] && !pin_sync[1])
                                            : (!pin_sync[2] && pin_sync[1]);
    always_comb begin
        timer_tick = control[`COR_CTL_SRC] ? pin_edge : 1'b1; // see [RQ2]
        if (!control[`COR_CTL_PSA] && timer_tick) begin
            timer_tick = prescale == ((8'h02 << control[2:0]) - 8'h01); // see [RQ3]
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            timer <= 8'h00;
            prescale <= 8'h00;
        end else if (timer_wr) begin
            timer <= wdata; // see [RQ2]
            prescale <= 8'h00; // see [RQ3]
        end else begin
            if (timer_tick) begin
                timer <= timer + 8'h01;
            end
            if (!control[`COR_CTL_PSA] && (control[`COR_CTL_SRC] ? pin_edge : 1'b1)) begin
                prescale <= timer_tick ? 8'h00 : prescale + 8'h01;
            end
        end
    end

    // ****************************************
    // status, select, table pointer, wake
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status <= `COR_STATUS_RESET; // see [RQ15] [RQ16]
            control <= 8'h00;
            brs <= 8'h00;
            table_pointer_low <= 8'h00;
            wake_en <= 8'h00;
        end else begin
            if (instr_go) begin
                unique case (op)
                    COR_OP_SLEEP: begin
                        status[`COR_ST_TO] <= 1'b1; // see [RQ15]
                        status[`COR_ST_PD] <= 1'b0; // see [RQ16]
                    end
                    COR_OP_WDTCLR: begin
                        status[`COR_ST_TO] <= 1'b1; // see [RQ15]
                        status[`COR_ST_PD] <= 1'b1; // see [RQ16]
                    end
                    COR_OP_WDTOUT: status[`COR_ST_TO] <= 1'b0; // see [RQ15]
                    COR_OP_ADDPC: begin
                        status[`COR_ST_Z] <= add_sum[7:0] == 8'h00; // see [RQ17]
                        status[`COR_ST_C] <= add_sum[8];
                        status[`COR_ST_HC] <= ({1'b0, PC[3:0]} + {1'b0, accum[3:0]}) > 5'h0F;
                    end
                    default: status <= status;
                endcase
            end else if (wr && WB_ADR_I == `COR_ADR_STATUS) begin
                status[2:0] <= wdata[2:0]; // see [RQ17]
            end
            if (wr && WB_ADR_I == `COR_ADR_CONTROL) control <= wdata;
            if (wr && WB_ADR_I == `COR_ADR_BRS) brs <= wdata; // see [RQ14]
            if (wr && WB_ADR_I == `COR_ADR_TABLE_POINTER_LOW) table_pointer_low <= wdata;
            if (wr && WB_ADR_I == `COR_ADR_WAKE) wake_en <= wdata & `COR_WAKE_MASK;
        end
    end

    // data memory: 16 shared bytes then four 32-byte banks
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < `COR_MEM_DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (indirect_wr && mem_hit) begin
            mem[mem_idx] <= wdata; // see [RQ1] [RQ21]
        end
    end

    // ****************************************
    // wake sources
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            p6_sync <= 2'b00;
            ext_sync <= 3'b000;
            cd_sync <= 2'b00;
            WAKE <= 1'b0;
        end else begin
            p6_sync <= {p6_sync[0], PORT6_CHANGE};
            ext_sync <= {ext_sync[1:0], EXT_PIN};
            cd_sync <= {cd_sync[0], CONV_DONE};
            WAKE <= (wake_en[`COR_WK_PORT] && p6_sync[1]) // see [RQ18]
                 || (wake_en[`COR_WK_CONV] && cd_sync[1]) // see [RQ19]
                 || (wake_en[`COR_WK_EXT] && ext_sync[2] && !ext_sync[1]); // see [RQ20]
        end
    end

    // ****************************************
    // checks
    // ****************************************
    reset_pc_a: assert property (@(posedge CLK) $rose(RESET_N) |-> PC == 12'h000) // see [RQ5]
        else $error("pc not zero after reset");
    jmp_page_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ6]
        instr_go && op == COR_OP_JMP |=> PC[11:10] == $past(PC[11:10]))
        else $error("short jump left page");
    long_jump_load_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ8]
        instr_go && op == COR_OP_LONG_JUMP |=> PC == $past(opnd))
        else $error("long jump target wrong");
    call_push_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ9]
        instr_go && op == COR_OP_LONG_CALL |=> stack[sp - 3'h1] == $past(PC) + 12'h001)
        else $error("call return address wrong");
    ret_pop_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ10]
        instr_go && op == COR_OP_RET |=> PC == $past(top) && sp == $past(sp) - 3'h1)
        else $error("return did not pop");
    pcl_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ12]
        pcl_wr && !instr_go |=> PC == {$past(PC[11:8]), $past(wdata)})
        else $error("low pc write touched upper bits");
    two_cycle_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ13]
        instr_go && op == COR_OP_LONG_JUMP |=> !WB_ACK_O ##1 WB_ACK_O)
        else $error("long jump not two cycles");
    sleep_flags_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ16]
        instr_go && op == COR_OP_SLEEP |=> status[4:3] == 2'b10)
        else $error("sleep flags wrong");
    timer_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ3]
        timer_wr |=> prescale == 8'h00 && timer == $past(wdata))
        else $error("timer write did not clear prescaler");
    jmp_low_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ6]
        instr_go && op == COR_OP_JMP |=> PC[9:0] == $past(opnd[9:0]))
        else $error("short jump low bits wrong");
    call_low_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ7]
        instr_go && op == COR_OP_CALL |=> PC[9:0] == $past(opnd[9:0])
            && stack[sp - 3'h1] == $past(PC) + 12'h001)
        else $error("short call wrong");
    addpc_sum_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ11]
        instr_go && op == COR_OP_ADDPC |=> PC == $past(PC) + {4'h0, $past(accum)})
        else $error("relative add lost its carry");
    busy_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ13]
        BUSY |=> !BUSY && WB_ACK_O)
        else $error("second cycle not followed by ack");
    wdt_flags_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ15] [RQ16]
        instr_go && op == COR_OP_WDTCLR |=> status[4:3] == 2'b11)
        else $error("watchdog clear flags wrong");
    wdt_out_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ15]
        instr_go && op == COR_OP_WDTOUT |=> !status[4])
        else $error("time-out flag not cleared");
    timer_step_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ2]
        !timer_wr && timer_tick |=> timer == $past(timer) + 8'h01)
        else $error("timer did not count");
    wake_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RQ18] [RQ20]
        (wake_en & `COR_WAKE_MASK) == 8'h00 |=> !WAKE)
        else $error("wake raised with all sources disabled");
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "cor_defines.svh"
module tb_top;
    import cor_pkg::*;
    // ****************
    // bench signals and model state
    // ****************
    localparam int LAT_ONE = 2;
    localparam int LAT_TWO = 3;
    localparam logic [7:0] ADR_TABLE = 8'h24;
    localparam logic [7:0] ADR_UNMAPPED = 8'h4C;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic timer_pin = 1'b0;
    logic port6 = 1'b0;
    logic ext_pin = 1'b1;
    logic conv = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic wake;
    logic [11:0] pc_o;
    logic busy;
    logic [11:0] pc_m = 12'h000;
    logic [11:0] stk[$];
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int busy_cyc = 0;

    always #12.5 clk = ~clk;

    cor_core dut (
        .CLK(clk), .RESET_N(reset_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .TIMER_PIN(timer_pin),
        .PORT6_CHANGE(port6), .EXT_PIN(ext_pin), .CONV_DONE(conv),
        .WAKE(wake), .PC(pc_o), .BUSY(busy)
    );

    // ****************
    // shared tasks
    // ****************
    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // lat counts edges from request launch to the edge that samples ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output int lat);
        lat = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        busy_cyc = 0;
        do begin
            @(posedge clk);
            lat++;
            if (busy === 1'b1) busy_cyc++;
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic ins(input logic [3:0] op, input logic [11:0] opnd);
        logic [31:0] q;
        int lat;
        wb(1'b1, `COR_ADR_OPERAND, {20'h0, opnd}, q, lat);
        wb(1'b1, `COR_ADR_INSTR, {28'h0, op}, q, lat);
        chk(lat, (op >= 4'h1 && op <= 4'h7) ? LAT_TWO : LAT_ONE);
        chk(busy_cyc, (op >= 4'h1 && op <= 4'h7) ? 1 : 0);
        case (op)
            4'h1: pc_m[9:0] = opnd[9:0];
            4'h2: begin
                stk.push_back(pc_m + 12'h1);
                pc_m[9:0] = opnd[9:0];
            end
            4'h3: pc_m = opnd;
            4'h4: begin
                stk.push_back(pc_m + 12'h1);
                pc_m = opnd;
            end
            4'h5: pc_m = stk.pop_back();
            4'h6: pc_m = pc_m + {4'h0, opnd[7:0]};
            4'hB: pc_m = pc_m + 12'h1;
            default: ;
        endcase
        if (op < 4'h7 || op == 4'hB) begin
            chk({20'h0, pc_o}, {20'h0, pc_m});
        end
    endtask

    task automatic pin_to(input logic v);
        @(posedge clk);
        timer_pin <= v;
        repeat (6) @(posedge clk);
    endtask

    // ****************
    // timeout
    // ****************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            end_sim();
        end
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        logic [31:0] q;
        logic [31:0] q2;
        logic [7:0] v[4];
        logic [7:0] t;
        logic hit;
        int lat;
        void'($urandom(32'hd729891c));
        repeat (2) @(posedge clk);
        chk({20'h0, pc_o}, 32'h0);
        reset_n <= 1'b1;
        wb(1'b0, `COR_ADR_STATUS, 32'h0, q, lat);
        chk(q, 32'h18);
        wb(1'b1, `COR_ADR_STATUS, 32'hFF, q, lat);
        wb(1'b0, `COR_ADR_STATUS, 32'h0, q, lat);
        chk(q, 32'h1F);
        wb(1'b1, `COR_ADR_STATUS, 32'h0, q, lat);
        wb(1'b0, `COR_ADR_STATUS, 32'h0, q, lat);
        chk(q, 32'h18);
        foreach (v[i]) v[i] = 8'($urandom);
        wb(1'b1, `COR_ADR_BRS, {24'h0, v[0]}, q, lat);
        wb(1'b0, `COR_ADR_BRS, 32'h0, q, lat);
        chk(q, {24'h0, v[0]});
        wb(1'b1, ADR_TABLE, {24'h0, v[1]}, q, lat);
        wb(1'b0, ADR_TABLE, 32'h0, q, lat);
        chk(q, {24'h0, v[1]});
        wb(1'b1, ADR_UNMAPPED, {24'h0, v[2]}, q, lat);
        wb(1'b0, ADR_UNMAPPED, 32'h0, q, lat);
        chk(q, 32'h0);
        // banked area keeps one byte per bank, common area is shared
        for (int b = 0; b < 4; b++) begin
            wb(1'b1, `COR_ADR_BRS, {24'h0, 2'(b), 6'h25}, q, lat);
            wb(1'b1, `COR_ADR_INDIRECT, {24'h0, v[b]}, q, lat);
        end
        for (int b = 0; b < 4; b++) begin
            wb(1'b1, `COR_ADR_BRS, {24'h0, 2'(b), 6'h25}, q, lat);
            wb(1'b0, `COR_ADR_INDIRECT, 32'h0, q, lat);
            chk(q, {24'h0, v[b]});
        end
        wb(1'b1, `COR_ADR_BRS, 32'h13, q, lat);
        wb(1'b1, `COR_ADR_INDIRECT, {24'h0, v[3]}, q, lat);
        wb(1'b1, `COR_ADR_BRS, 32'hD3, q, lat);
        wb(1'b0, `COR_ADR_INDIRECT, 32'h0, q, lat);
        chk(q, {24'h0, v[3]});
        ins(4'h8, 12'h0);
        wb(1'b0, `COR_ADR_STATUS, 32'h0, q, lat);
        chk(q & 32'hF8, 32'h10);
        ins(4'h9, 12'h0);
        wb(1'b0, `COR_ADR_STATUS, 32'h0, q, lat);
        chk(q & 32'hF8, 32'h18);
        ins(4'hA, 12'h0);
        wb(1'b0, `COR_ADR_STATUS, 32'h0, q, lat);
        chk(q & 32'h10, 32'h0);
        ins(4'h3, 12'hBFE);
        ins(4'h6, 12'h005);
        ins(4'h1, 12'($urandom));
        ins(4'h2, 12'($urandom));
        ins(4'h4, 12'($urandom));
        ins(4'h5, 12'h0);
        ins(4'h5, 12'h0);
        ins(4'hB, 12'h0);
        ins(4'h7, 12'h0);
        ins(4'h3, 12'hB55);
        for (int i = 0; i < 8; i++) ins(4'h4, 12'($urandom));
        for (int i = 0; i < 8; i++) ins(4'h5, 12'h0);
        wb(1'b1, `COR_ADR_PCL, {24'h0, v[2]}, q, lat);
        chk(lat, LAT_TWO);
        chk(busy_cyc, 1);
        pc_m[7:0] = v[2];
        chk({20'h0, pc_o}, {20'h0, pc_m});
        wb(1'b0, `COR_ADR_PCFULL, 32'h0, q, lat);
        chk(q, {20'h0, pc_m});
        // timer from pin, rising then falling polarity, prescaler elsewhere
        t = 8'($urandom);
        wb(1'b1, `COR_ADR_CONTROL, 32'h28, q, lat);
        wb(1'b1, `COR_ADR_TIMER, {24'h0, t}, q, lat);
        pin_to(1'b1);
        pin_to(1'b0);
        wb(1'b0, `COR_ADR_TIMER, 32'h0, q, lat);
        chk(q, {24'h0, t + 8'h1});
        wb(1'b1, `COR_ADR_CONTROL, 32'h38, q, lat);
        pin_to(1'b1);
        wb(1'b1, `COR_ADR_TIMER, {24'h0, t}, q, lat);
        pin_to(1'b0);
        pin_to(1'b1);
        wb(1'b0, `COR_ADR_TIMER, 32'h0, q, lat);
        chk(q, {24'h0, t + 8'h1});
        pin_to(1'b0);
        // prescaler on timer at divide by two; a timer write clears it
        wb(1'b1, `COR_ADR_CONTROL, 32'h20, q, lat);
        wb(1'b1, `COR_ADR_TIMER, 32'h0, q, lat);
        repeat (4) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        wb(1'b0, `COR_ADR_TIMER, 32'h0, q, lat);
        chk(q, 32'h2);
        pin_to(1'b1);
        pin_to(1'b0);
        wb(1'b1, `COR_ADR_TIMER, 32'h0, q, lat);
        pin_to(1'b1);
        pin_to(1'b0);
        wb(1'b0, `COR_ADR_TIMER, 32'h0, q, lat);
        chk(q, 32'h0);
        wb(1'b1, `COR_ADR_CONTROL, 32'h08, q, lat);
        wb(1'b0, `COR_ADR_TIMER, 32'h0, q, lat);
        wb(1'b0, `COR_ADR_TIMER, 32'h0, q2, lat);
        chk({31'h0, q2[7:0] != q[7:0]}, 32'h1);
        // wake sources gated by their enables
        wb(1'b1, `COR_ADR_WAKE, 32'hFF, q, lat);
        wb(1'b0, `COR_ADR_WAKE, 32'h0, q, lat);
        chk(q, 32'h70);
        wb(1'b1, `COR_ADR_WAKE, 32'h0, q, lat);
        port6 <= 1'b1;
        ext_pin <= 1'b0;
        conv <= 1'b1;
        repeat (8) @(posedge clk);
        chk({31'h0, wake}, 32'h0);
        wb(1'b1, `COR_ADR_WAKE, 32'h40, q, lat);
        repeat (8) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        // the external pin wakes on a falling edge, so give it a fresh one
        wb(1'b1, `COR_ADR_WAKE, 32'h10, q, lat);
        ext_pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, wake}, 32'h0);
        ext_pin <= 1'b0;
        hit = 1'b0;
        repeat (8) begin
            @(posedge clk);
            hit = hit | wake;
        end
        chk({31'h0, hit}, 32'h1);
        wb(1'b1, `COR_ADR_WAKE, 32'h20, q, lat);
        repeat (8) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        end_sim();
    end
endmodule
